// ==== rtl/dcs_arbiter.sv ====
// four-level priority arbiter with static or round-robin order per level
`timescale 1ns/1ps
module dcs_arbiter import dcs_pkg::*; #(
  parameter int NCH = 6,
  parameter int CHW = 3
) (
  // requests
  input wire logic [NCH-1:0] req,
  input wire logic [NCH-1:0][1:0] lvl,
  // level control
  input wire logic [NLVL-1:0] lvl_en,
  input wire logic [NLVL-1:0] rr_en,
  input wire logic [NLVL-1:0][CHW-1:0] last,
  // grant
  output logic gnt_v,
  output logic [CHW-1:0] gnt_ch
);
  // first requester at or after start, wrapping
  function automatic logic [CHW:0] pick(input logic [NCH-1:0] r, input int start);
    logic [CHW:0] res;
    int idx;
    res = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      idx = (start + k) % NCH;
      if (r[idx]) res = {1'b1, CHW'(idx)};
    end
    return res;
  endfunction

  always_comb begin
    logic [NCH-1:0] m;
    logic [CHW:0] p;
    int st;
    m = '0;
    p = '0;
    st = 0;
    gnt_v = 1'b0;
    gnt_ch = '0;
    // walk levels high to low so the lowest enabled level wins
    for (int l = NLVL - 1; l >= 0; l--) begin
      for (int c = 0; c < NCH; c++) begin
        m[c] = req[c] && (int'(lvl[c]) == l);
      end
      // last winner gets the lowest rank next time
      st = rr_en[l] ? (int'(last[l]) + 1) % NCH : 0;
      p = pick(m, st);
      if (lvl_en[l] && p[CHW]) begin
        gnt_v = 1'b1;
        gnt_ch = p[CHW-1:0];
      end
    end
  end
endmodule // dcs_arbiter

// ==== rtl/dcs_pkg.sv ====
// shared constants, carriers and state codes for the dma channel scheduler
package dcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DBASE = 8'h04;
  localparam logic [7:0] OFF_WBASE = 8'h08;
  localparam logic [7:0] OFF_CHSEL = 8'h0C;
  localparam logic [7:0] OFF_CHCTRL = 8'h10;
  localparam logic [7:0] OFF_CHCMD = 8'h14;
  localparam logic [7:0] OFF_CHSTAT = 8'h18;
  localparam logic [7:0] OFF_PEND = 8'h1C;
  localparam logic [7:0] OFF_BUSY = 8'h20;
  localparam logic [7:0] OFF_ACTIVE = 8'h24;
  localparam logic [7:0] OFF_PRIO = 8'h28;
  // control register fields
  localparam int NLVL = 4;
  localparam int CT_LVLEN = 0;
  localparam int CT_RREN = 4;
  // channel control fields
  localparam int CC_EN = 0;
  localparam int CC_LVL = 4;
  localparam int CC_TSRC = 8;
  localparam int CC_TACT = 12;
  localparam int CC_EVB = 16;
  localparam int CC_EVK = 17;
  // channel command bits
  localparam int CM_TRIG = 0;
  localparam int CM_SUSP = 1;
  localparam int CM_RESUME = 2;
  // channel status bits; 2..5 are write-one-to-clear
  localparam int ST_PEND = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_FERR = 2;
  localparam int ST_TERR = 3;
  localparam int ST_TCMP = 4;
  localparam int ST_SUSF = 5;
  localparam int ST_SUSP = 6;
  // descriptor layout: word0 control+count, word1 source, word2 dest, word3 next
  localparam int D_VALID = 0;
  localparam int D_BACT = 3;
  localparam int D_BACT_SUS = 4;
  localparam int D_CNT = 16;
  localparam int CNT_W = 16;
  localparam int DESC_SHIFT = 4;
  localparam int WORD_SHIFT = 2;
  localparam logic [31:0] NULL_PTR = 32'h0000_0000;
  // trigger sources and actions
  localparam logic [1:0] TSRC_SW = 2'h0;
  localparam logic [1:0] TSRC_PER = 2'h1;
  localparam logic [1:0] TSRC_EVT = 2'h2;
  localparam logic [1:0] TACT_BLOCK = 2'h0;
  localparam logic [1:0] TACT_BEAT = 2'h2;
  localparam logic [1:0] TACT_TRANS = 2'h3;

  typedef enum logic [2:0] {S_IDLE, S_SAVE, S_FETCH, S_BEAT, S_WB, S_NEXT, S_COPY} dcs_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcs_mem_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } dcs_mem_rsp_s;
  typedef struct packed {
    logic req;
    logic [31:0] src;
    logic [31:0] dst;
  } dcs_dat_req_s;
  typedef struct packed {
    logic ack;
    logic err;
  } dcs_dat_rsp_s;
endpackage

// ==== rtl/dcs_scheduler.sv ====
// dma channel scheduler: apb registers, trigger queue, descriptor and beat engine
// Operation
// - first descriptors sit contiguously from the descriptor base, by channel
// - ongoing descriptors kept contiguously from the write-back base, by channel
// - trigger on enabled unsuspended channel queues it and sets its pending bit
// - grant clears pending and sets busy on the first burst
// - after a burst, requeue keeps busy; wait, suspend or disable clear it
// - suspended pending channel leaves the queue, keeps pending, rejoins on resume
// - disabling a pending channel removes it and clears pending
// - level executing flag set while a channel of that level pends or runs
// - four levels, lower number wins, only enabled levels arbitrate
// - static order within a level grants the lowest channel number
// - round robin stores last winner per level and ranks it lowest
// - grant fetches descriptor from descriptor or write-back region, then moves data
// - arbitrate every burst, decrement count, save count on switch, beat event
// - at zero count clear valid, write back descriptor, flags and block event
// - null next pointer ends transaction with suspend or disable per block action
// - nonzero next pointer is fetched and copied to write-back before arbitrating
// - trigger starts block, beat or transaction; channel disables after last block unless its block action suspends
// - one trigger held pending during a transfer, further ones dropped
// - busy set at start, cleared when the trigger action ends, mirrored
// - trigger source per channel is software, peripheral or event
// - each burst is one atomic beat
// - bus error disables channel, flags error, saves undecremented count
// - invalid descriptor or resume onto null pointer suspends with fetch error
`timescale 1ns/1ps
module dcs_scheduler import dcs_pkg::*; #(
  parameter int NCH = 6,
  parameter int CHW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources
  input wire logic [NCH-1:0] periph_trig,
  input wire logic [NCH-1:0] event_trig,
  // descriptor fetch bus
  output dcs_mem_req_s fetch_o,
  input wire dcs_mem_rsp_s fetch_i,
  // data bus
  output dcs_dat_req_s data_o,
  input wire dcs_dat_rsp_s data_i,
  // events
  output logic [NCH-1:0] beat_evt,
  output logic [NCH-1:0] block_evt
);
  typedef struct packed {
    dcs_state_e st;
    logic [1:0] wi;
    logic save_err;
    logic [CHW-1:0] cur;
    logic [CHW-1:0] ld_ch;
    logic ld_v;
    logic [3:0][31:0] d;
    logic [NCH-1:0] en, sus, pend, busy, run, ong, nul;
    logic [NCH-1:0] ferr, terr, tcmp, susf, evb, evk;
    logic [NCH-1:0][1:0] lvl, tsrc, tact;
    logic [NCH-1:0] ps1, ps2, ps3, es1, es2, es3;
    logic [NLVL-1:0] lvl_en, rr_en, lexec;
    logic [NLVL-1:0][CHW-1:0] last;
    logic [31:0] dbase, wbase;
    logic [CHW-1:0] chsel;
    logic pready, pslverr;
    logic [31:0] prdata;
    dcs_mem_req_s mem;
    dcs_dat_req_s dat;
    logic [NCH-1:0] bevt, kevt;
  } dcs_state_s;

  dcs_state_s state_r;
  dcs_state_s state_nxt;
  logic [NCH-1:0] arb_req;
  logic gnt_v;
  logic [CHW-1:0] gnt_ch;
  logic [1:0] gnt_lvl;
  logic [CNT_W-1:0] cur_cnt;
  logic [NLVL-1:0] lexec_calc;

  // entry address inside a region
  function automatic logic [31:0] ent(input logic [31:0] base, input logic [CHW-1:0] ch,
                                      input logic [1:0] w);
    return base + (32'(ch) << DESC_SHIFT) + (32'(w) << WORD_SHIFT);
  endfunction

  // suspended channels stay pending but drop out of the queue
  assign arb_req = state_r.en & ~state_r.sus & (state_r.run | (state_r.pend & ~state_r.busy));
  assign gnt_lvl = state_r.lvl[gnt_ch];
  assign cur_cnt = state_r.d[0][D_CNT +: CNT_W];

  dcs_arbiter #(.NCH(NCH), .CHW(CHW)) u_arb (
    .req(arb_req),
    .lvl(state_r.lvl),
    .lvl_en(state_r.lvl_en),
    .rr_en(state_r.rr_en),
    .last(state_r.last),
    .gnt_v(gnt_v),
    .gnt_ch(gnt_ch)
  );

  always_comb begin
    for (int l = 0; l < NLVL; l++) begin
      lexec_calc[l] = 1'b0;
      for (int c = 0; c < NCH; c++) begin
        if ((state_r.pend[c] || state_r.busy[c]) && int'(state_r.lvl[c]) == l) begin
          lexec_calc[l] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    dcs_state_s r;
    dcs_state_s n;
    logic [31:0] rd;
    logic [NCH-1:0] swt;
    logic [NCH-1:0] trig;
    logic [CHW-1:0] c;
    logic [CNT_W-1:0] dec;
    logic wr;
    r = state_r;
    n = state_r;
    rd = '0;
    swt = '0;
    trig = '0;
    c = r.cur;
    dec = cur_cnt - CNT_W'(1);
    wr = psel && penable && pwrite && r.pready;
    n.bevt = '0;
    n.kevt = '0;
    n.lexec = lexec_calc;
    // pins pass two flops; the third only feeds the edge detector
    n.ps1 = periph_trig;
    n.ps2 = r.ps1;
    n.ps3 = r.ps2;
    n.es1 = event_trig;
    n.es2 = r.es1;
    n.es3 = r.es2;
    // apb: one wait cycle, registered answer
    n.pready = psel && penable && !r.pready;
    n.pslverr = 1'b0;
    case (paddr)
      OFF_CTRL: rd = 32'({r.rr_en, r.lvl_en});
      OFF_DBASE: rd = r.dbase;
      OFF_WBASE: rd = r.wbase;
      OFF_CHSEL: rd = 32'(r.chsel);
      OFF_CHCTRL: rd = (32'(r.en[r.chsel]) << CC_EN) | (32'(r.lvl[r.chsel]) << CC_LVL) |
                       (32'(r.tsrc[r.chsel]) << CC_TSRC) | (32'(r.tact[r.chsel]) << CC_TACT) |
                       (32'(r.evb[r.chsel]) << CC_EVB) | (32'(r.evk[r.chsel]) << CC_EVK);
      OFF_CHCMD: rd = '0;
      OFF_CHSTAT: rd = (32'(r.pend[r.chsel]) << ST_PEND) | (32'(r.busy[r.chsel]) << ST_BUSY) |
                       (32'(r.ferr[r.chsel]) << ST_FERR) | (32'(r.terr[r.chsel]) << ST_TERR) |
                       (32'(r.tcmp[r.chsel]) << ST_TCMP) | (32'(r.susf[r.chsel]) << ST_SUSF) |
                       (32'(r.sus[r.chsel]) << ST_SUSP);
      OFF_PEND: rd = 32'(r.pend);
      OFF_BUSY: rd = 32'(r.busy);
      OFF_ACTIVE: rd = 32'(r.lexec);
      OFF_PRIO: rd = 32'(r.last);
      default: begin
        rd = '0;
        n.pslverr = psel && penable && !r.pready;
      end
    endcase
    n.prdata = (psel && penable && !r.pready) ? rd : r.prdata;
    if (wr) begin
      case (paddr)
        OFF_CTRL: begin
          n.lvl_en = pwdata[CT_LVLEN +: NLVL];
          n.rr_en = pwdata[CT_RREN +: NLVL];
        end
        OFF_DBASE: n.dbase = pwdata;
        OFF_WBASE: n.wbase = pwdata;
        OFF_CHSEL: if (pwdata < NCH) n.chsel = pwdata[CHW-1:0];
        OFF_CHCTRL: begin
          n.lvl[r.chsel] = pwdata[CC_LVL +: 2];
          if (!r.en[r.chsel]) begin
            // source and action only change while the channel is off
            n.tsrc[r.chsel] = pwdata[CC_TSRC +: 2];
            n.tact[r.chsel] = pwdata[CC_TACT +: 2];
            n.evb[r.chsel] = pwdata[CC_EVB];
            n.evk[r.chsel] = pwdata[CC_EVK];
            n.ong[r.chsel] = 1'b0;
            n.nul[r.chsel] = 1'b0;
            n.sus[r.chsel] = 1'b0;
          end
          n.en[r.chsel] = pwdata[CC_EN];
          if (!pwdata[CC_EN]) begin
            n.pend[r.chsel] = 1'b0;
            n.run[r.chsel] = 1'b0;
            n.busy[r.chsel] = 1'b0;
          end
        end
        OFF_CHCMD: begin
          swt[r.chsel] = pwdata[CM_TRIG];
          if (pwdata[CM_SUSP]) n.sus[r.chsel] = 1'b1;
          if (pwdata[CM_RESUME] && r.sus[r.chsel]) begin
            if (r.nul[r.chsel]) begin
              n.ferr[r.chsel] = 1'b1;
              n.susf[r.chsel] = 1'b1;
            end else begin
              n.sus[r.chsel] = 1'b0;
            end
          end
        end
        OFF_CHSTAT: begin
          if (pwdata[ST_FERR]) n.ferr[r.chsel] = 1'b0;
          if (pwdata[ST_TERR]) n.terr[r.chsel] = 1'b0;
          if (pwdata[ST_TCMP]) n.tcmp[r.chsel] = 1'b0;
          if (pwdata[ST_SUSF]) n.susf[r.chsel] = 1'b0;
        end
        default: ;
      endcase
    end
    // engine: flag sets come after software clears so an event is never lost
    case (r.st)
      S_IDLE: begin
        if (gnt_v) begin
          c = gnt_ch;
          n.cur = c;
          n.last[gnt_lvl] = c;
          if (!r.run[c]) n.pend[c] = 1'b0;
          n.busy[c] = 1'b1;
          n.run[c] = 1'b1;
          if (r.ld_v && r.ld_ch == c) begin
            n.st = S_BEAT;
          end else if (r.ld_v) begin
            n.save_err = 1'b0;
            n.st = S_SAVE;
          end else begin
            n.wi = '0;
            n.st = S_FETCH;
          end
        end
      end
      S_SAVE: begin
        if (!r.mem.req) begin
          n.mem = '{1'b1, 1'b1, ent(r.wbase, r.ld_ch, 2'h0), r.d[0]};
        end else if (fetch_i.ack) begin
          n.mem.req = 1'b0;
          n.wi = '0;
          n.st = S_FETCH;
          if (r.save_err) begin
            n.en[c] = 1'b0;
            n.pend[c] = 1'b0;
            n.busy[c] = 1'b0;
            n.run[c] = 1'b0;
            n.ld_v = 1'b0;
            n.st = S_IDLE;
          end
        end
      end
      S_FETCH: begin
        if (!r.mem.req) begin
          n.mem = '{1'b1, 1'b0, ent(r.ong[c] ? r.wbase : r.dbase, c, r.wi), 32'h0};
        end else if (fetch_i.ack) begin
          n.mem.req = 1'b0;
          n.d[r.wi] = fetch_i.rdata;
          n.wi = r.wi + 2'h1;
          if (r.wi == 2'h3) begin
            n.ld_v = 1'b1;
            n.ld_ch = c;
            n.ong[c] = 1'b1;
            n.st = S_BEAT;
            if (!r.d[0][D_VALID]) begin
              n.sus[c] = 1'b1;
              n.ferr[c] = 1'b1;
              n.susf[c] = 1'b1;
              n.busy[c] = 1'b0;
              n.ld_v = 1'b0;
              n.st = S_IDLE;
            end
          end
        end
      end
      S_BEAT: begin
        // one beat per burst, never split
        if (!r.dat.req) begin
          n.dat = '{1'b1, r.d[1], r.d[2]};
        end else if (data_i.ack) begin
          n.dat.req = 1'b0;
          n.st = S_IDLE;
          if (data_i.err) begin
            n.terr[c] = 1'b1;
            n.save_err = 1'b1;
            n.st = S_SAVE;
          end else begin
            n.d[0][D_CNT +: CNT_W] = dec;
            n.bevt[c] = r.evb[c];
            if (dec == '0) begin
              n.d[0][D_VALID] = 1'b0;
              n.wi = '0;
              n.st = S_WB;
            end else if (r.tact[c] == TACT_BEAT || r.sus[c]) begin
              n.busy[c] = 1'b0;
              if (r.tact[c] == TACT_BEAT) n.run[c] = 1'b0;
            end
          end
        end
      end
      S_WB: begin
        if (!r.mem.req) begin
          n.mem = '{1'b1, 1'b1, ent(r.wbase, c, r.wi), r.d[r.wi]};
        end else if (fetch_i.ack) begin
          n.mem.req = 1'b0;
          n.wi = r.wi + 2'h1;
          if (r.wi == 2'h3) begin
            n.tcmp[c] = 1'b1;
            n.kevt[c] = r.evk[c];
            n.wi = '0;
            n.st = S_NEXT;
            if (r.d[0][D_BACT_SUS]) begin
              n.sus[c] = 1'b1;
              n.susf[c] = 1'b1;
            end
            if (r.d[3] == NULL_PTR) begin
              // transaction over: suspend or disable per block action
              if (!r.d[0][D_BACT_SUS]) n.en[c] = 1'b0;
              n.nul[c] = r.d[0][D_BACT_SUS];
              n.ong[c] = 1'b0;
              n.pend[c] = r.d[0][D_BACT_SUS] && r.pend[c];
              n.busy[c] = 1'b0;
              n.run[c] = 1'b0;
              n.ld_v = 1'b0;
              n.st = S_IDLE;
            end
          end
        end
      end
      S_NEXT: begin
        // word 3 is replaced last, so the pointer holds for the whole fetch
        if (!r.mem.req) begin
          n.mem = '{1'b1, 1'b0, r.d[3] + (32'(r.wi) << WORD_SHIFT), 32'h0};
        end else if (fetch_i.ack) begin
          n.mem.req = 1'b0;
          n.d[r.wi] = fetch_i.rdata;
          n.wi = r.wi + 2'h1;
          if (r.wi == 2'h3) n.st = S_COPY;
        end
      end
      S_COPY: begin
        if (!r.mem.req) begin
          n.mem = '{1'b1, 1'b1, ent(r.wbase, c, r.wi), r.d[r.wi]};
        end else if (fetch_i.ack) begin
          n.mem.req = 1'b0;
          n.wi = r.wi + 2'h1;
          if (r.wi == 2'h3) begin
            n.st = S_IDLE;
            if (!r.d[0][D_VALID]) begin
              n.sus[c] = 1'b1;
              n.ferr[c] = 1'b1;
              n.susf[c] = 1'b1;
              n.ld_v = 1'b0;
            end
            if (r.tact[c] != TACT_TRANS || !r.d[0][D_VALID] || r.sus[c]) begin
              n.busy[c] = 1'b0;
              if (r.tact[c] != TACT_TRANS) n.run[c] = 1'b0;
            end
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
    // triggers: a second one while one is held is dropped
    for (int k = 0; k < NCH; k++) begin
      trig[k] = (r.tsrc[k] == TSRC_PER && r.ps2[k] && !r.ps3[k]) ||
                (r.tsrc[k] == TSRC_EVT && r.es2[k] && !r.es3[k]) ||
                (r.tsrc[k] == TSRC_SW && swt[k]);
      if (trig[k] && n.en[k] && !r.sus[k]) n.pend[k] = 1'b1;
    end
    state_nxt = n;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign fetch_o = state_r.mem;
  assign data_o = state_r.dat;
  assign beat_evt = state_r.bevt;
  assign block_evt = state_r.kevt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_grant_busy: assert property ((state_r.st == S_IDLE && gnt_v) |=> state_r.busy[$past(gnt_ch)])
    else $error("granted channel not busy");
  chk_rr_store: assert property ((state_r.st == S_IDLE && gnt_v) |=>
                                 state_r.last[$past(gnt_lvl)] == $past(gnt_ch))
    else $error("last granted channel not stored");
  chk_grant_legal: assert property (gnt_v |-> arb_req[gnt_ch] && state_r.lvl_en[gnt_lvl])
    else $error("grant to a channel that did not request");
  chk_pend_enabled: assert property ((state_r.pend & ~state_r.en) == '0)
    else $error("pending bit on disabled channel");
  chk_level_exec: assert property ((|(state_r.pend | state_r.busy)) |=> (|state_r.lexec))
    else $error("level executing flag wrong");
  chk_beat_dec: assert property ((state_r.st == S_BEAT && state_r.dat.req && data_i.ack &&
                                  !data_i.err) |=> cur_cnt == $past(cur_cnt) - 16'h0001)
    else $error("beat count not decremented");
  chk_err_hold: assert property ((state_r.st == S_BEAT && state_r.dat.req && data_i.ack &&
                                  data_i.err) |=> state_r.st == S_SAVE && $stable(cur_cnt))
    else $error("error path changed count");
  chk_block_end: assert property ((state_r.st == S_BEAT && state_r.dat.req && data_i.ack &&
                                   !data_i.err && cur_cnt == 16'h0001) |=>
                                  state_r.st == S_WB && !state_r.d[0][D_VALID])
    else $error("block end did not clear valid");
  chk_fetch_hold: assert property ((fetch_o.req && !fetch_i.ack) |=>
                                   fetch_o.req && $stable(fetch_o.addr))
    else $error("fetch request dropped early");
endmodule // dcs_scheduler

// ==== testbench/dcs_mem_model.sv ====
// sram and data-bus partner model for the dma channel scheduler
`timescale 1ns/1ps
module dcs_mem_model import dcs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // buses
  input wire dcs_mem_req_s fetch_o,
  output dcs_mem_rsp_s fetch_i,
  input wire dcs_dat_req_s data_o,
  output dcs_dat_rsp_s data_i,
  // behaviour
  input wire logic [3:0] wait_cyc,
  input wire logic err_inj
);
  logic [31:0] mem [0:63];
  logic [3:0] fcnt_r;
  logic [3:0] dcnt_r;
  // plain always: the bench preloads mem from outside this process
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_i <= '0;
      data_i <= '0;
      fcnt_r <= '0;
      dcnt_r <= '0;
    end else begin
      fetch_i.ack <= 1'b0;
      // read data is not held after ack
      fetch_i.rdata <= ~fetch_i.rdata;
      data_i <= '0;
      fcnt_r <= 4'h0;
      dcnt_r <= 4'h0;
      // no re-ack in the ack cycle; req still high there
      if (fetch_o.req && !fetch_i.ack) begin
        fcnt_r <= fcnt_r + 4'h1;
        if (fcnt_r == wait_cyc) begin
          fetch_i.ack <= 1'b1;
          fetch_i.rdata <= mem[fetch_o.addr[7:2]];
          if (fetch_o.we) begin
            mem[fetch_o.addr[7:2]] <= fetch_o.wdata;
          end
        end
      end
      if (data_o.req && !data_i.ack) begin
        dcnt_r <= dcnt_r + 4'h1;
        if (dcnt_r == wait_cyc) begin
          data_i.ack <= 1'b1;
          data_i.err <= err_inj;
        end
      end
    end
  end
endmodule // dcs_mem_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the dma channel scheduler
`timescale 1ns/1ps
module tb_top import dcs_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err_inj, lerr, got1, gotf;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fsrc, fdst, faddr, q;
  logic [5:0] periph_trig, event_trig, beat_evt, block_evt;
  logic [3:0] wait_cyc;
  dcs_mem_req_s fetch_o;
  dcs_mem_rsp_s fetch_i;
  dcs_dat_req_s data_o;
  dcs_dat_rsp_s data_i;
  int err_count, n_tests, nbeat, nblk;
  dcs_scheduler u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_trig(periph_trig), .event_trig(event_trig),
    .fetch_o(fetch_o), .fetch_i(fetch_i), .data_o(data_o), .data_i(data_i),
    .beat_evt(beat_evt), .block_evt(block_evt));
  dcs_mem_model u_mem (.clk(clk), .rst_n(rst_n), .fetch_o(fetch_o), .fetch_i(fetch_i),
    .data_o(data_o), .data_i(data_i), .wait_cyc(wait_cyc), .err_inj(err_inj));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // sample mid-cycle so registered pulses are settled
  always @(negedge clk) begin
    nbeat += $countones(beat_evt);
    nblk += $countones(block_evt);
    if (data_o.req && data_i.ack && !got1) begin
      fsrc = data_o.src;
      fdst = data_o.dst;
      got1 = 1'b1;
    end
    if (fetch_o.req && !gotf) begin
      faddr = fetch_o.addr;
      gotf = 1'b1;
    end
  end
  // only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input int i, input logic [31:0] w0, input logic [31:0] s);
    u_mem.mem[i*4] = w0;
    u_mem.mem[i*4+1] = s;
    u_mem.mem[i*4+2] = s + 32'h0000_0100;
    u_mem.mem[i*4+3] = 32'h0000_0000;
  endtask
  task automatic setch(input logic [31:0] ch, input logic [31:0] cc);
    apb(1'b1, OFF_CHSEL, ch);
    apb(1'b1, OFF_CHCTRL, cc);
  endtask
  task automatic clr;
    nbeat = 0;
    nblk = 0;
    got1 = 1'b0;
    gotf = 1'b0;
  endtask
  // polls until nothing is busy or pending, bounded
  task automatic idle;
    logic done;
    done = 1'b0;
    for (int i = 0; i < 100 && !done; i++) begin
      apb(1'b0, OFF_BUSY, 32'h0);
      done = (q === 32'h0);
      apb(1'b0, OFF_PEND, 32'h0);
      done = done && (q === 32'h0);
    end
    chk(32'(done), 32'h1);
  endtask
  task automatic t_single;
    wait_cyc <= 4'h3;
    put(1, 32'h0002_0001, 32'h0000_1000);
    apb(1'b1, OFF_CTRL, 32'h1);
    setch(1, 32'h0003_0001);
    clr();
    apb(1'b1, OFF_CHCMD, 32'h1);
    idle();
    chk(faddr, 32'h0000_0010);
    chk(fsrc, 32'h0000_1000);
    chk(fdst, 32'h0000_1100);
    chk(32'(nbeat), 32'h2);
    chk(32'(nblk), 32'h1);
    chk(u_mem.mem[36], 32'h0000_0000);
    chk(u_mem.mem[37], 32'h0000_1000);
    apb(1'b0, OFF_CHCTRL, 32'h0);
    chk(32'(q[CC_EN]), 32'h0);
    $display("test single block done");
  endtask
  task automatic t_static;
    wait_cyc <= 4'h0;
    put(2, 32'h0001_0001, 32'h0000_3000);
    put(3, 32'h0001_0001, 32'h0000_4000);
    apb(1'b1, OFF_CTRL, 32'h0);
    setch(2, 32'h0003_0011);
    setch(3, 32'h0003_0111);
    clr();
    // two peripheral edges; the second finds one pending already
    for (int k = 0; k < 2; k++) begin
      periph_trig[3] <= 1'b1;
      repeat (6) @(posedge clk);
      periph_trig[3] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    apb(1'b1, OFF_CHSEL, 32'h2);
    apb(1'b1, OFF_CHCMD, 32'h1);
    apb(1'b0, OFF_PEND, 32'h0);
    chk(q, 32'h0000_000C);
    apb(1'b1, OFF_CTRL, 32'h2);
    idle();
    chk(fsrc, 32'h0000_3000);
    chk(32'(nbeat), 32'h2);
    apb(1'b0, OFF_PRIO, 32'h0);
    chk(q, 32'h0000_0019);
    $display("test static order done");
  endtask
  task automatic t_link;
    put(4, 32'h0001_0001, 32'h0000_7000);
    put(14, 32'h0001_0001, 32'h0000_6000);
    u_mem.mem[19] = 32'h0000_00E0;
    apb(1'b1, OFF_CTRL, 32'h4);
    setch(4, 32'h0002_0221);
    clr();
    // two event edges: first block then the linked last block
    for (int k = 0; k < 2; k++) begin
      event_trig[4] <= 1'b1;
      repeat (6) @(posedge clk);
      event_trig[4] <= 1'b0;
      idle();
      if (k == 0) chk(u_mem.mem[49], 32'h0000_6000);
      apb(1'b0, OFF_CHCTRL, 32'h0);
      chk(32'(q[CC_EN]), 32'(1 - k));
    end
    chk(faddr, 32'h0000_0040);
    chk(fsrc, 32'h0000_7000);
    chk(32'(nbeat), 32'h0);
    chk(32'(nblk), 32'h2);
    $display("test linked blocks done");
  endtask
  task automatic t_error;
    err_inj <= 1'b1;
    put(0, 32'h0003_0001, 32'h0000_5000);
    apb(1'b1, OFF_CTRL, 32'h1);
    setch(0, 32'h0000_0001);
    apb(1'b1, OFF_CHCMD, 32'h1);
    idle();
    chk(u_mem.mem[32] >> 16, 32'h3);
    apb(1'b0, OFF_CHSTAT, 32'h0);
    chk(32'(q[ST_TERR]), 32'h1);
    apb(1'b0, OFF_CHCTRL, 32'h0);
    chk(32'(q[CC_EN]), 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(lerr), 32'h1);
    err_inj <= 1'b0;
    $display("test bus error done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // generous span: the four tests need a few hundred cycles
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    {rst_n, psel, penable, pwrite, err_inj} = '0;
    {paddr, pwdata, periph_trig, event_trig, wait_cyc} = '0;
    {err_count, n_tests} = '0;
    clr();
    for (int i = 0; i < 64; i++) begin
      u_mem.mem[i] = 32'h0000_0000;
    end
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, OFF_DBASE, 32'h0000_0000);
    apb(1'b1, OFF_WBASE, 32'h0000_0080);
    t_single();
    t_static();
    t_error();
    t_link();
    report_and_stop();
  end
endmodule // tb_top
